/* File: logic/sbx_pkg.sv */
// Shared constants for the two-port bus segment expander
package sbx_pkg;

    // ************************************************************
    // Line map: 16 data, 2 parity, 9 control
    // ************************************************************
    localparam int unsigned N_LINES  = 27;
    localparam int unsigned LN_P0    = 16;
    localparam int unsigned LN_P1    = 17;
    localparam int unsigned LN_BSY   = 18;
    localparam int unsigned LN_SEL   = 19;
    localparam int unsigned LN_RST   = 20;
    localparam int unsigned LN_ATN   = 21;
    localparam int unsigned LN_MSG   = 22;
    localparam int unsigned LN_CD    = 23;
    localparam int unsigned LN_IO    = 24;
    localparam int unsigned LN_REQ   = 25;
    localparam int unsigned LN_ACK   = 26;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned HOLD_NS       = 200;
    localparam int unsigned SETUP_NS      = 100;
    localparam int unsigned RECOV_NS      = 100;
    localparam int unsigned HOLD_CYC  =
        (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETUP_CYC =
        (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECOV_CYC =
        (RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W     = 3;

    // ************************************************************
    // Per-line forwarding states
    // ************************************************************
    typedef enum logic [4:0] {
        SBX_IDLE    = 5'h01,
        SBX_DELAY   = 5'h02,
        SBX_HOLD    = 5'h04,
        SBX_FOLLOW  = 5'h08,
        SBX_RECOVER = 5'h10
    } sbx_fwd_e;

    localparam logic DETACHED_RST = 1'b0;

endpackage

/* File: logic/sbx_fwd_cell.sv */
// One bus line forwarder: direction sense, filter, delay, recovery
module sbx_fwd_cell (
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic act_i,
    input  wire logic dly_en_i,
    input  wire logic a_ast_i,
    input  wire logic b_ast_i,
    output logic      a_drv_o,
    output logic      b_drv_o,
    output logic      busy_o
);
    import sbx_pkg::*;

    sbx_fwd_e           st_q;
    logic               dir_q;
    logic               drv_q;
    logic [CNT_W-1:0]   cnt_q;
    logic               src;

    // Only the side recorded as source is watched; our own drive is blind
    assign src = dir_q ? b_ast_i : a_ast_i;

    // ************************************************************
    // Forwarding sequence
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st_q  <= SBX_IDLE;
            dir_q <= 1'b0;
            drv_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            case (st_q)
                SBX_IDLE: begin
                    // Both sides asserted by others: nothing to pass
                    if (act_i && (a_ast_i ^ b_ast_i)) begin
                        dir_q <= b_ast_i;
                        if (dly_en_i) begin
                            st_q  <= SBX_DELAY;
                            cnt_q <= CNT_W'(SETUP_CYC - 1);
                        end else begin
                            st_q  <= SBX_HOLD;
                            cnt_q <= CNT_W'(HOLD_CYC - 1);
                            drv_q <= 1'b1;
                        end
                    end
                end
                SBX_DELAY: begin
                    // Pulse shorter than the setup delay is dropped
                    if (!src) begin
                        st_q <= SBX_IDLE;
                    end else if (cnt_q == '0) begin
                        st_q  <= SBX_HOLD;
                        cnt_q <= CNT_W'(HOLD_CYC - 1);
                        drv_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                SBX_HOLD: begin
                    // Input bounce ignored while the edge is held
                    if (cnt_q == '0) begin
                        st_q <= SBX_FOLLOW;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                SBX_FOLLOW: begin
                    if (!src) begin
                        drv_q <= 1'b0;
                        st_q  <= SBX_RECOVER;
                        cnt_q <= CNT_W'(RECOV_CYC - 1);
                    end
                end
                SBX_RECOVER: begin
                    // Lets our released line settle before sensing again
                    if (cnt_q == '0) begin
                        st_q <= SBX_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    st_q  <= SBX_IDLE;
                    drv_q <= 1'b0;
                end
            endcase
        end
    end

    assign a_drv_o = drv_q & dir_q;
    assign b_drv_o = drv_q & ~dir_q;
    assign busy_o  = (st_q != SBX_IDLE);

endmodule

/* File: logic/sbx_expander.sv */
// Two-port bus segment expander top with line forwarders
//
// Contract
// - Single-ended and differential port two modes
// - Disable detaches buses without corrupting transfers
// - Forward data and parity source to load
// - Enable drivers only opposite the source
// - Re-time forwarded signals to hold skew
// - Any async or sync rate, no configuration
// - Never arbitrate or answer selection itself
// - Initiators and targets on either port
// - Timing valid with three expanders cascaded
// - Port two has per-line driver enables
// - No software registers, bus signals govern
// - Full wide or narrow data set forwarded
// - Never forward an assertion we drove
// - Hold assertion edge, then follow input
// - Delay data clock leading edge for setup
module sbx_expander (
    input  wire logic                         core_clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         disable_i,
    input  wire logic                         diff_mode_i,
    input  wire logic [sbx_pkg::N_LINES-1:0]  a_ln_i,
    output logic      [sbx_pkg::N_LINES-1:0]  a_ln_o,
    output logic      [sbx_pkg::N_LINES-1:0]  a_ln_oe_o,
    input  wire logic [sbx_pkg::N_LINES-1:0]  b_ln_i,
    output logic      [sbx_pkg::N_LINES-1:0]  b_ln_o,
    output logic      [sbx_pkg::N_LINES-1:0]  b_ln_oe_o,
    output logic      [sbx_pkg::N_LINES-1:0]  b_de_o,
    output logic                              detached_o
);
    import sbx_pkg::*;

    logic [N_LINES-1:0] a_ast;
    logic [N_LINES-1:0] b_ast;
    logic [N_LINES-1:0] a_drv;
    logic [N_LINES-1:0] b_drv;
    logic [N_LINES-1:0] busy;
    logic [N_LINES-1:0] dly_en;
    logic               detached_q;
    logic               bus_free;
    logic               data_clk;
    logic               fwd_act;

    // ************************************************************
    // Line sensing (low level on the wire means asserted)
    // ************************************************************
    // No own ID and no registers: only sensed lines steer us
    assign a_ast = ~a_ln_i;
    assign b_ast = ~b_ln_i;

    assign bus_free = !(a_ast[LN_BSY] | b_ast[LN_BSY]
                      | a_ast[LN_SEL] | b_ast[LN_SEL]) && (busy == '0);

    // Data phase: REQ/ACK clock data when both MSG and C/D are negated
    assign data_clk = (a_ast[LN_BSY] | b_ast[LN_BSY])
                    & ~(a_ast[LN_MSG] | b_ast[LN_MSG])
                    & ~(a_ast[LN_CD] | b_ast[LN_CD]);

    // ************************************************************
    // Detach control
    // ************************************************************
    // Change only at bus free so a running transfer finishes intact
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            detached_q <= DETACHED_RST;
        end else if (bus_free && (disable_i != detached_q)) begin
            detached_q <= disable_i;
        end
    end

    assign detached_o = detached_q;

    // No new take on the detaching edge, else a drive outlives it
    assign fwd_act = !(detached_q || (disable_i && bus_free));

    // ************************************************************
    // Per-line forwarders; all 18 data/parity lines always carried
    // ************************************************************
    // Fixed latency per hop keeps a three-deep cascade within budget
    for (genvar i = 0; i < N_LINES; i++) begin : g_line
        assign dly_en[i] = ((i == LN_REQ) || (i == LN_ACK)) && data_clk;
        sbx_fwd_cell u_cell (
            .core_clk_i (core_clk_i),
            .rst_i      (rst_i),
            .act_i      (fwd_act),
            .dly_en_i   (dly_en[i]),
            .a_ast_i    (a_ast[i]),
            .b_ast_i    (b_ast[i]),
            .a_drv_o    (a_drv[i]),
            .b_drv_o    (b_drv[i]),
            .busy_o     (busy[i])
        );

        // ********************************************************
        // Per-line checks
        // ********************************************************
        a_src_only_b: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            $rose(b_drv[i]) |-> $past(a_ast[i]))
            else $error("Port two drive without port one source");

        a_src_only_a: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            $rose(a_drv[i]) |-> $past(b_ast[i]))
            else $error("Port one drive without port two source");

        a_hold_b: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            $rose(b_drv[i]) |-> b_drv[i] [*3])
            else $error("Port two edge not held");

        a_hold_a: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            $rose(a_drv[i]) |-> a_drv[i] [*3])
            else $error("Port one edge not held");

        a_follow_b: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            (b_drv[i] && $past(b_drv[i]) && $past(b_drv[i], 2))
            |=> (b_drv[i] == $past(a_ast[i])))
            else $error("Port two drive not following source");

        a_follow_a: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            (a_drv[i] && $past(a_drv[i]) && $past(a_drv[i], 2))
            |=> (a_drv[i] == $past(b_ast[i])))
            else $error("Port one drive not following source");

        a_turn_b: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            $fell(b_drv[i]) |-> !a_drv[i] ##1 !a_drv[i])
            else $error("Turnaround to port one before recovery");

        a_turn_a: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            $fell(a_drv[i]) |-> !b_drv[i] ##1 !b_drv[i])
            else $error("Turnaround to port two before recovery");

        a_fwd_b: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            (!busy[i] && fwd_act && !dly_en[i]
             && a_ast[i] && !b_ast[i])
            |=> b_drv[i])
            else $error("Port one assertion not forwarded");

        a_fwd_a: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            (!busy[i] && fwd_act && !dly_en[i]
             && b_ast[i] && !a_ast[i])
            |=> a_drv[i])
            else $error("Port two assertion not forwarded");

        a_delay_b: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            (!busy[i] && fwd_act && dly_en[i]
             && a_ast[i] && !b_ast[i])
            |=> !b_drv[i] ##1 (b_drv[i] == $past(a_ast[i])))
            else $error("Port two data clock not delayed");

        a_delay_a: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            (!busy[i] && fwd_act && dly_en[i]
             && b_ast[i] && !a_ast[i])
            |=> !a_drv[i] ##1 (a_drv[i] == $past(b_ast[i])))
            else $error("Port one data clock not delayed");

        a_both_quiet: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            (!busy[i] && a_ast[i] && b_ast[i])
            |=> !(a_drv[i] || b_drv[i]))
            else $error("Forwarded a line asserted on both ports");

        a_refuse_off: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            (!busy[i] && !fwd_act) |=> !(a_drv[i] || b_drv[i]))
            else $error("Line taken while detached");
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    // Open-collector style: pins only pull low, terminators pull high
    assign a_ln_o    = '0;
    assign b_ln_o    = '0;
    assign a_ln_oe_o = a_drv;
    // Differential mode steers external transceivers instead
    assign b_ln_oe_o = b_drv & {N_LINES{~diff_mode_i}};
    assign b_de_o    = b_drv & {N_LINES{diff_mode_i}};

    // ************************************************************
    // Checks
    // ************************************************************
    a_one_direction: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (a_drv & b_drv) == '0)
        else $error("Line driven on both ports");

    a_detached_quiet: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        detached_q |-> (a_ln_oe_o == '0 && b_ln_oe_o == '0
                        && b_de_o == '0))
        else $error("Driver active while detached");

    a_detach_busfree: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        $changed(detached_q) |-> $past(bus_free))
        else $error("Detach changed during a transfer");

    a_mode_steer: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        diff_mode_i |-> (b_ln_oe_o == '0 && b_de_o == b_drv))
        else $error("Differential steering wrong");

    a_data_forward: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!busy[0] && a_ast[0] && !b_ast[0] && fwd_act)
        |=> b_drv[0])
        else $error("Data assertion not forwarded next cycle");

    a_edge_hold: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        $rose(b_drv[0]) |-> b_drv[0] [*2])
        else $error("Assertion edge not held");

    a_req_delay: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!busy[LN_REQ] && b_ast[LN_REQ] && !a_ast[LN_REQ]
         && fwd_act && data_clk)
        |=> !a_drv[LN_REQ]
            ##1 (a_drv[LN_REQ] == $past(b_ast[LN_REQ])))
        else $error("Data clock edge not delayed by one cycle");

    a_no_echo: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (b_drv[0] && !a_ast[0]) |=> !a_drv[0])
        else $error("Own drive echoed back");

    a_drive_cause: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        $rose(a_drv[0]) |-> $past(b_ast[0]))
        else $error("Drive without a source assertion");

    a_detach_cause: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        $rose(detached_q) |-> $past(disable_i))
        else $error("Detached without a request");

    a_attach_cause: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        $fell(detached_q) |-> !$past(disable_i))
        else $error("Attached while still requested off");

    a_detached_idle: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        detached_q |-> (busy == '0))
        else $error("Line busy while detached");

    a_busy_freeze: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (busy != '0) |=> $stable(detached_q))
        else $error("Detach moved while a line was busy");

    a_attach_apply: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (bus_free && (disable_i != detached_q))
        |=> (detached_q == $past(disable_i)))
        else $error("Detach request not applied at bus free");

    a_se_steer: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        !diff_mode_i |-> (b_de_o == '0 && b_ln_oe_o == b_drv))
        else $error("Single-ended steering wrong");

endmodule

/* File: dv/sbx_bus_model.sv */
// Two wired bus segments with pull-ups, devices and expander pulling low
module sbx_bus_model (
    input  wire logic                        diff_mode_i,
    input  wire logic [sbx_pkg::N_LINES-1:0] a_dev_i,
    input  wire logic [sbx_pkg::N_LINES-1:0] b_dev_i,
    input  wire logic [sbx_pkg::N_LINES-1:0] a_oe_i,
    input  wire logic [sbx_pkg::N_LINES-1:0] b_oe_i,
    input  wire logic [sbx_pkg::N_LINES-1:0] b_de_i,
    output logic      [sbx_pkg::N_LINES-1:0] a_ln_o,
    output logic      [sbx_pkg::N_LINES-1:0] b_ln_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import sbx_pkg::*;

    // Released lines float up to the terminator level, never hold old data
    assign a_ln_o = ~(a_dev_i | a_oe_i);
    // Differential side is steered only by the external driver enables
    assign b_ln_o = ~(b_dev_i | (diff_mode_i ? b_de_i : b_oe_i));
endmodule

/* File: dv/sbx_expander_tb.sv */
// Self-checking bench for the bus segment expander
module sbx_expander_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sbx_pkg::*;

    logic               clk;
    logic               rst;
    logic               dis;
    logic               diff;
    logic [N_LINES-1:0] a_dev;
    logic [N_LINES-1:0] b_dev;
    logic [N_LINES-1:0] a_ln;
    logic [N_LINES-1:0] b_ln;
    logic [N_LINES-1:0] a_oe;
    logic [N_LINES-1:0] b_oe;
    logic [N_LINES-1:0] b_de;
    logic [N_LINES-1:0] a_val;
    logic [N_LINES-1:0] b_val;
    logic               det;
    int                 n_mismatch;
    int                 n_tests;
    int                 cyc;

    sbx_expander dut (
        .core_clk_i(clk), .rst_i(rst), .disable_i(dis),
        .diff_mode_i(diff), .a_ln_i(a_ln), .a_ln_o(a_val),
        .a_ln_oe_o(a_oe), .b_ln_i(b_ln), .b_ln_o(b_val),
        .b_ln_oe_o(b_oe), .b_de_o(b_de), .detached_o(det)
    );
    sbx_bus_model bus (
        .diff_mode_i(diff), .a_dev_i(a_dev), .b_dev_i(b_dev),
        .a_oe_i(a_oe), .b_oe_i(b_oe), .b_de_i(b_de),
        .a_ln_o(a_ln), .b_ln_o(b_ln)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Ceiling well above the at most 136 cycles the tests need
    initial cyc = 0;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic tick(input int n = 1);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic chk(input string nm, input logic [26:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Short glitch on the full wide set still gets the held edge
    task automatic t_wide();
        a_dev[17:0] = '1;
        a_dev[LN_RST] = 1'b1;
        b_dev[LN_RST] = 1'b1;
        tick(2);
        chk("b_oe", b_oe, 27'h003_ffff);
        a_dev = '0;
        b_dev = '0;
        tick();
        chk("b_oe hold", b_oe, 27'h003_ffff);
        chk("a_oe echo", a_oe, '0);
        tick();
        chk("b_oe drop", b_oe, '0);
        tick(3);
        $display("test wide done");
    endtask

    // Differential port two, both directions
    task automatic t_diff();
        diff = 1'b1;
        a_dev[6] = 1'b1;
        tick(2);
        chk("b_de", b_de, 27'h000_0040);
        chk("b_oe se", b_oe, '0);
        a_dev = '0;
        tick(5);
        b_dev[5] = 1'b1;
        tick(2);
        chk("a_oe", a_oe, 27'h000_0020);
        chk("b_de off", b_de, '0);
        tick(4);
        chk("a_oe follow", a_oe, 27'h000_0020);
        b_dev = '0;
        tick(2);
        chk("a_oe drop", a_oe, '0);
        tick(3);
        diff = 1'b0;
        $display("test diff done");
    endtask

    // Transfer clock delay only in data phase
    task automatic t_req();
        a_dev[LN_BSY] = 1'b1;
        tick(3);
        b_dev[LN_REQ] = 1'b1;
        tick();
        chk("req c1", a_oe[LN_REQ], 1'b0);
        tick();
        chk("req c2", a_oe[LN_REQ], 1'b1);
        b_dev[LN_REQ] = 1'b0;
        a_dev[LN_ACK] = 1'b1;
        tick();
        chk("ack c1", b_oe[LN_ACK], 1'b0);
        tick();
        chk("ack c2", b_oe[LN_ACK], 1'b1);
        a_dev[LN_ACK] = 1'b0;
        tick(5);
        b_dev[LN_CD] = 1'b1;
        tick(3);
        b_dev[LN_REQ] = 1'b1;
        tick();
        chk("req ctl", a_oe[LN_REQ], 1'b1);
        a_dev = '0;
        b_dev = '0;
        tick(6);
        $display("test req done");
    endtask

    task automatic wait_det(input logic v);
        repeat (12)
            if (det !== v)
                tick();
        chk("detached", det, v);
    endtask

    // Detach at idle, then a request during a busy transfer
    task automatic t_dis();
        dis = 1'b1;
        wait_det(1'b1);
        a_dev[3] = 1'b1;
        tick(3);
        chk("b_oe det", b_oe, '0);
        chk("a_oe det", a_oe, '0);
        a_dev = '0;
        dis = 1'b0;
        wait_det(1'b0);
        tick(2);
        a_dev[LN_BSY] = 1'b1;
        tick(3);
        dis = 1'b1;
        tick(3);
        chk("busy kept", det, 1'b0);
        chk("bsy fwd", b_oe[LN_BSY], 1'b1);
        a_dev = '0;
        wait_det(1'b1);
        dis = 1'b0;
        wait_det(1'b0);
        $display("test disable done");
    endtask

    initial begin
        n_mismatch = 0;
        n_tests = 0;
        rst = 1'b1;
        dis = 1'b0;
        diff = 1'b0;
        a_dev = '0;
        b_dev = '0;
        tick(20);
        chk("rst a_oe", a_oe, '0);
        chk("rst det", det, 1'b0);
        rst = 1'b0;
        tick(10);
        chk("idle a_oe", a_oe, '0);
        chk("idle b_oe", b_oe | b_de, '0);
        chk("pin value", a_val | b_val, '0);
        t_wide();
        t_diff();
        t_req();
        t_dis();
        report_and_stop();
    end
endmodule
